/* design/power_mode_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none


module power_mode_ctrl
    import power_mode_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               reset,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Wake and reset sources
    input  wire logic               irq_request,
    input  wire logic [1:0]         ext_int_n,
    input  wire logic               adc_compare_wake,
    input  wire logic               hw_reset_n,
    // Section clock gating and control
    output logic                    cpu_clk_en,
    output logic                    acq_clk_en,
    output logic                    disp_clk_en,
    output logic                    periph_clk_en,
    output logic                    osc_en,
    output logic                    state_hold,
    output logic                    core_reset,
    output logic                    irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    power_state_t       state_reg;
    power_state_t       state_next;
    logic [POWER_CONTROL_REGISTER_W-1:0]  power_control_register_reg;
    logic [POWER_CONTROL_REGISTER_W-1:0]  power_control_register_sw;
    logic [POWER_CONTROL_REGISTER_W-1:0]  power_control_register_next;
    logic [WAKE_W-1:0]  wake_en_reg;
    logic [WAKE_W-1:0]  wake_en_next;
    logic [EV_W-1:0]    irq_stat_reg;
    logic [EV_W-1:0]    irq_stat_next;
    logic [EV_W-1:0]    irq_mask_reg;
    logic [EV_W-1:0]    irq_mask_next;
    logic [EV_W-1:0]    events;
    logic [EV_W-1:0]    ev_clear;
    logic [CNT_W-1:0]   osc_cnt_reg;
    logic [CNT_W-1:0]   osc_cnt_next;
    logic [CNT_W-1:0]   rst_cnt_reg;
    logic [CNT_W-1:0]   rst_cnt_next;
    logic [SYNC_W-1:0]  pins_s;

    logic               aw_full_reg;
    logic               w_full_reg;
    logic [ADDR_W-1:0]  awaddr_reg;
    logic [31:0]        wdata_reg;
    logic [3:0]         wstrb_reg;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    pin_sync #(
        .W    (SYNC_W),
        .INIT (SYNC_INIT)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in ({hw_reset_n, adc_compare_wake, ext_int_n}),
        .sync_out (pins_s)
    );

    // ************************************************************
    // Wake and reset decode
    // ************************************************************
    wire int0_wake = wake_en_reg[WAKE_INT0_BIT] & ~pins_s[0];
    wire int1_wake = wake_en_reg[WAKE_INT1_BIT] & ~pins_s[1];
    // Only levels are seen: no edge can be caught while stopped
    wire ext_wake  = int0_wake | int1_wake;
    wire adc_wake  = wake_en_reg[WAKE_ADC_BIT] & pins_s[SYNC_ADC];
    wire idle_wake = irq_request | ext_wake | adc_wake;
    wire pd_wake   = ext_wake | adc_wake;

    wire rst_pin_low = ~pins_s[SYNC_RST];
    // Counter saturates so a long reset is held, not re-fired
    assign rst_cnt_next = !rst_pin_low ? CNT_ZERO :
                          (rst_cnt_reg == RESET_COUNT) ? rst_cnt_reg :
                          rst_cnt_reg + CNT_ONE;
    wire rst_long  = rst_pin_low & (rst_cnt_next == RESET_COUNT);
    wire rst_start = rst_long & (rst_cnt_reg != RESET_COUNT);

    // ************************************************************
    // AXI4-Lite decode
    // ************************************************************
    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire ar_take  = s_axi_arvalid & s_axi_arready;
    wire do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    wire byte0_wr = do_write & wstrb_reg[0];

    wire wa_power_control_register  = awaddr_reg == ADDR_POWER_CONTROL_REGISTER;
    wire wa_wake  = awaddr_reg == ADDR_WAKE_EN;
    wire wa_stat  = awaddr_reg == ADDR_STATUS;
    wire wa_istat = awaddr_reg == ADDR_IRQ_STAT;
    wire wa_imask = awaddr_reg == ADDR_IRQ_MASK;
    wire wa_hit   = wa_power_control_register | wa_wake | wa_stat | wa_istat | wa_imask;

    wire aw_full_next = aw_take | (aw_full_reg & ~do_write);
    wire w_full_next  = w_take | (w_full_reg & ~do_write);
    wire bvalid_next  = do_write | (s_axi_bvalid & ~s_axi_bready);
    wire rvalid_next  = ar_take | (s_axi_rvalid & ~s_axi_rready);

    // Status is read-only: a write there is answered but has no effect
    wire [1:0] bresp_next = wa_hit ? RESP_OKAY : RESP_SLVERR;

    wire [31:0] st_word = {29'h0000000, osc_en, state_reg};
    logic [31:0] rdata_next;
    logic [1:0]  rresp_next;
    always_comb begin
        rresp_next = RESP_OKAY;
        if (s_axi_araddr == ADDR_POWER_CONTROL_REGISTER) begin
            rdata_next = {30'h0, power_control_register_reg};
        end else if (s_axi_araddr == ADDR_WAKE_EN) begin
            rdata_next = {29'h0, wake_en_reg};
        end else if (s_axi_araddr == ADDR_STATUS) begin
            rdata_next = st_word;
        end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
            rdata_next = {29'h0, irq_stat_reg};
        end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
            rdata_next = {29'h0, irq_mask_reg};
        end else begin
            rdata_next = 32'h00000000;
            rresp_next = RESP_SLVERR;
        end
    end

    // ************************************************************
    // Power control register and state machine
    // ************************************************************
    assign power_control_register_sw = (byte0_wr & wa_power_control_register) ? wdata_reg[POWER_CONTROL_REGISTER_W-1:0] :
                     power_control_register_reg;

    wire osc_done = osc_cnt_reg == OSC_COUNT;

    always_comb begin
        state_next   = state_reg;
        power_control_register_next    = power_control_register_sw;
        osc_cnt_next = CNT_ZERO;
        case (state_reg)
            ST_RUN: begin
                if (power_control_register_reg[POWER_CONTROL_REGISTER_PD_BIT]) begin
                    state_next = ST_PD;
                end else if (power_control_register_reg[POWER_CONTROL_REGISTER_IDLE_BIT]) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (idle_wake) begin
                    state_next = ST_RUN;
                    power_control_register_next[POWER_CONTROL_REGISTER_IDLE_BIT] = 1'b0;
                end
            end
            ST_PD: begin
                if (pd_wake) begin
                    state_next = ST_OSC_WAIT;
                    // Both bits drop, else a stale idle bit re-enters idle
                    power_control_register_next  = POWER_CONTROL_REGISTER_RESET;
                end
            end
            ST_OSC_WAIT: begin
                osc_cnt_next = osc_cnt_reg + CNT_ONE;
                if (osc_done) begin
                    state_next   = ST_RUN;
                    osc_cnt_next = CNT_ZERO;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        // External reset wins from any mode
        if (rst_long) begin
            state_next   = ST_RUN;
            power_control_register_next    = POWER_CONTROL_REGISTER_RESET;
            osc_cnt_next = CNT_ZERO;
        end
    end

    // ************************************************************
    // Clock gating outputs
    // ************************************************************
    wire run_next   = state_next == ST_RUN;
    wire osc_next   = state_next != ST_PD;
    // Peripherals wait for the crystal just like the CPU does
    wire per_next   = (state_next == ST_RUN) |
                      (state_next == ST_IDLE);
    wire hold_next  = ~run_next;

    // ************************************************************
    // Events and interrupt
    // ************************************************************
    assign events[EV_IDLE_EXIT] = (state_reg == ST_IDLE) &
                                  (state_next == ST_RUN);
    assign events[EV_PD_EXIT]   = (state_reg == ST_OSC_WAIT) &
                                  (state_next == ST_RUN);
    assign events[EV_HW_RESET]  = rst_start;

    assign ev_clear = (byte0_wr & wa_istat) ?
                      wdata_reg[EV_W-1:0] : EV_RESET;
    // New event wins over a clear in the same cycle
    assign irq_stat_next = (irq_stat_reg & ~ev_clear) | events;
    assign irq_mask_next = (byte0_wr & wa_imask) ?
                           wdata_reg[EV_W-1:0] : irq_mask_reg;
    assign wake_en_next  = (byte0_wr & wa_wake) ?
                           wdata_reg[WAKE_W-1:0] : wake_en_reg;

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg    <= ST_RUN;
            power_control_register_reg     <= POWER_CONTROL_REGISTER_RESET;
            wake_en_reg  <= WAKE_RESET;
            irq_stat_reg <= EV_RESET;
            irq_mask_reg <= EV_RESET;
            osc_cnt_reg  <= CNT_ZERO;
            rst_cnt_reg  <= CNT_ZERO;
        end else begin
            state_reg    <= state_next;
            power_control_register_reg     <= power_control_register_next;
            wake_en_reg  <= wake_en_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            osc_cnt_reg  <= osc_cnt_next;
            rst_cnt_reg  <= rst_cnt_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cpu_clk_en    <= 1'b1;
            acq_clk_en    <= 1'b1;
            disp_clk_en   <= 1'b1;
            periph_clk_en <= 1'b1;
            osc_en        <= 1'b1;
            state_hold    <= 1'b0;
            core_reset    <= 1'b0;
            irq           <= 1'b0;
        end else begin
            cpu_clk_en    <= run_next;
            acq_clk_en    <= run_next;
            disp_clk_en   <= run_next;
            periph_clk_en <= per_next;
            osc_en        <= osc_next;
            state_hold    <= hold_next;
            core_reset    <= rst_long;
            irq           <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // ************************************************************
    // AXI4-Lite handshake registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h00000000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            aw_full_reg   <= aw_full_next;
            w_full_reg    <= w_full_next;
            s_axi_awready <= ~aw_full_next & ~bvalid_next;
            s_axi_wready  <= ~w_full_next & ~bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= bresp_next;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (ar_take) begin
                s_axi_rdata <= rdata_next;
                s_axi_rresp <= rresp_next;
            end
        end
    end

    // Software side keeps watchdog off and display blanked first
    // this block does not police either.

endmodule // power_mode_ctrl

`default_nettype wire

/* pkg/power_mode_pkg.sv */
package power_mode_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_PS    = 5000;
    // Two machine cycles of the crystal, 24 crystal clocks
    localparam int unsigned RESET_MIN_NS     = 2000;
    localparam int unsigned RESET_CYCLES     =
        (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned OSC_START_NS     = 10000;
    localparam int unsigned OSC_START_CYCLES =
        (OSC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          CNT_W            = 12;
    localparam logic [CNT_W-1:0] RESET_COUNT = CNT_W'(RESET_CYCLES);
    localparam logic [CNT_W-1:0] OSC_COUNT   = CNT_W'(OSC_START_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO    = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE     = 12'h001;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  ADDR_POWER_CONTROL_REGISTER      = 8'h00;
    localparam logic [7:0]  ADDR_WAKE_EN   = 8'h04;
    localparam logic [7:0]  ADDR_STATUS    = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0c;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h10;

    localparam int POWER_CONTROL_REGISTER_W          = 2;
    localparam int POWER_CONTROL_REGISTER_IDLE_BIT   = 0;
    localparam int POWER_CONTROL_REGISTER_PD_BIT     = 1;
    localparam int WAKE_W          = 3;
    localparam int WAKE_INT0_BIT   = 0;
    localparam int WAKE_INT1_BIT   = 1;
    localparam int WAKE_ADC_BIT    = 2;
    localparam int EV_W            = 3;
    localparam int EV_IDLE_EXIT    = 0;
    localparam int EV_PD_EXIT      = 1;
    localparam int EV_HW_RESET     = 2;

    localparam logic [POWER_CONTROL_REGISTER_W-1:0] POWER_CONTROL_REGISTER_RESET  = 2'h0;
    localparam logic [WAKE_W-1:0] WAKE_RESET  = 3'h0;
    localparam logic [EV_W-1:0]   EV_RESET    = 3'h0;

    // Sync order: {hw_reset_n, adc_wake, ext_int_n[1:0]}
    localparam int         SYNC_W      = 4;
    localparam logic [3:0] SYNC_INIT   = 4'hb;
    localparam int         SYNC_ADC    = 2;
    localparam int         SYNC_RST    = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_IDLE,
        ST_PD,
        ST_OSC_WAIT
    } power_state_t;

endpackage

/* design/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sync
    import power_mode_pkg::*;
#(
    parameter int              W    = 1,
    parameter logic [W-1:0]    INIT = '0
) (
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire logic [W-1:0]  async_in,
    output logic      [W-1:0]  sync_out
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // ************************************************************
    // Three stages, change taken when stages two and three agree
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    s1_reg[i]   <= INIT[i];
                    s2_reg[i]   <= INIT[i];
                    s3_reg[i]   <= INIT[i];
                    sync_out[i] <= INIT[i];
                end else begin
                    s1_reg[i] <= async_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        sync_out[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate

endmodule // pin_sync

`default_nettype wire

/* testbench/wake_source_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Wake and reset sources outside the block
// ****************************************
module wake_source_model (
    input  wire logic       sys_clk,
    output logic      [1:0] ext_int_n,
    output logic            adc_compare_wake,
    output logic            hw_reset_n,
    output logic            irq_request
);
    initial begin
        ext_int_n        = 2'h3;
        adc_compare_wake = 1'b0;
        hw_reset_n       = 1'b1;
        irq_request      = 1'b0;
    end

    // Levels, not edges: no clock runs to catch an edge in power-down
    task automatic wake(input int src);
        @(posedge sys_clk);
        if (src < 2) ext_int_n[src] <= 1'b0;
        else adc_compare_wake <= 1'b1;
        repeat (12) @(posedge sys_clk);
        ext_int_n        <= 2'h3;
        adc_compare_wake <= 1'b0;
    endtask

    task automatic set_reset(input logic level);
        @(posedge sys_clk);
        hw_reset_n <= level;
    endtask

    task automatic set_irq(input logic level);
        @(posedge sys_clk);
        irq_request <= level;
    endtask
endmodule // wake_source_model

`default_nettype wire

/* testbench/power_mode_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none

module power_mode_ctrl_props
    import power_mode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic irq_request,
    input wire logic hw_reset_n,
    input wire logic cpu_clk_en,
    input wire logic acq_clk_en,
    input wire logic disp_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_en,
    input wire logic state_hold,
    input wire logic core_reset
);
    // ****************************************
    // Raw length of the external reset pulse
    // ****************************************
    logic [CNT_W-1:0] low_cnt;

    always_ff @(posedge sys_clk) begin
        if (hw_reset_n) low_cnt <= CNT_ZERO;
        else if (low_cnt != '1) low_cnt <= low_cnt + CNT_ONE;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    gated_trio_a: assert property (
        acq_clk_en == cpu_clk_en && disp_clk_en == cpu_clk_en)
        else $error("Section enables disagree");
    idle_periph_a: assert property (
        $fell(cpu_clk_en) && osc_en |-> periph_clk_en)
        else $error("Peripheral clock lost on idle entry");
    freeze_hold_a: assert property (
        state_hold == !cpu_clk_en)
        else $error("Hold does not follow gated core");
    irq_wake_a: assert property (
        !cpu_clk_en && periph_clk_en && irq_request |=> cpu_clk_en)
        else $error("Interrupt did not end idle");
    pd_stop_a: assert property (
        $fell(periph_clk_en) |-> !osc_en && !cpu_clk_en)
        else $error("Oscillator still on in power-down");
    pd_deaf_a: assert property (
        !osc_en && irq_request && hw_reset_n |=> !cpu_clk_en)
        else $error("Core interrupt woke power-down");
    osc_first_a: assert property (
        $rose(osc_en) && !core_reset |-> !cpu_clk_en [*8])
        else $error("Clocks back before oscillator settled");
    reset_len_a: assert property (
        $rose(core_reset) |-> low_cnt >= RESET_COUNT
            && low_cnt <= RESET_COUNT + 12'h008)
        else $error("Reset length off");
    reset_run_a: assert property (
        $rose(core_reset) |-> ##[0:1] (cpu_clk_en && osc_en))
        else $error("Reset did not restore clocks");
endmodule // power_mode_ctrl_props

`default_nettype wire

/* testbench/power_mode_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module power_mode_ctrl_tb
    import power_mode_pkg::*;
;
    logic        sys_clk, reset, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic        awready, wready, bvalid, arready, rvalid, irq_request;
    logic [1:0]  bresp, rresp, ext_int_n;
    logic [3:0]  wstrb;
    logic        adc_compare_wake, hw_reset_n, cpu_clk_en, acq_clk_en;
    logic        disp_clk_en, periph_clk_en, osc_en, state_hold;
    logic        core_reset, irq;
    int          fail_count, comparisons, cycles, n;
    wire  [2:0]  watch = {core_reset, osc_en, cpu_clk_en};

    power_mode_ctrl dut (
        .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq_request(irq_request),
        .ext_int_n(ext_int_n), .adc_compare_wake(adc_compare_wake),
        .hw_reset_n(hw_reset_n), .cpu_clk_en(cpu_clk_en),
        .acq_clk_en(acq_clk_en), .disp_clk_en(disp_clk_en),
        .periph_clk_en(periph_clk_en), .osc_en(osc_en),
        .state_hold(state_hold), .core_reset(core_reset), .irq(irq));

    wake_source_model src (
        .sys_clk(sys_clk), .ext_int_n(ext_int_n),
        .adc_compare_wake(adc_compare_wake), .hw_reset_n(hw_reset_n),
        .irq_request(irq_request));

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, (a > ADDR_IRQ_MASK) ? RESP_SLVERR : RESP_OKAY);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] resp);
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, exp);
        chk(rresp, resp);
    endtask

    // Select 0 core clock, 1 oscillator, 2 core reset
    task automatic wait_en(input int sel, input logic v, input int lim);
        n = 0;
        while (n < lim && watch[sel] !== v) begin
            @(posedge sys_clk);
            n++;
        end
        #1;
        chk(watch[sel], v);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_idle();
        rchk(8'h14, 32'h0, RESP_SLVERR);
        chk({periph_clk_en, osc_en, state_hold, core_reset, irq}, 32'h18);
        wr(ADDR_IRQ_MASK, 32'h7);
        // Byte 0 strobe off, read-only and unmapped writes: no effect
        wstrb <= 4'he;
        wr(ADDR_POWER_CONTROL_REGISTER, 32'h1);
        wstrb <= 4'hf;
        rchk(ADDR_POWER_CONTROL_REGISTER, 32'h0, RESP_OKAY);
        wr(ADDR_STATUS, 32'h3);
        wr(8'h14, 32'h3);
        rchk(ADDR_STATUS, 32'h4, RESP_OKAY);
        // Core has watchdog off and display blanked before this
        wr(ADDR_POWER_CONTROL_REGISTER, 32'h1);
        wait_en(0, 1'b0, 10);
        chk({acq_clk_en, disp_clk_en, periph_clk_en, osc_en}, 32'h3);
        chk(state_hold, 32'h1);
        rchk(ADDR_STATUS, 32'h5, RESP_OKAY);
        src.set_irq(1'b1);
        wait_en(0, 1'b1, 4);
        src.set_irq(1'b0);
        rchk(ADDR_POWER_CONTROL_REGISTER, 32'h0, RESP_OKAY);
        rchk(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
        chk(irq, 32'h1);
        wr(ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1 chk(irq, 32'h0);
    endtask

    // Mode 1 idle, mode 3 both bits where power-down must win
    task automatic t_wake(input logic [31:0] mode);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_WAKE_EN, 32'h1 << i);
            wr(ADDR_POWER_CONTROL_REGISTER, mode);
            wait_en(int'(mode[1]), 1'b0, 10);
            if (mode[1]) begin
                chk({periph_clk_en, cpu_clk_en}, 32'h0);
                rchk(ADDR_STATUS, 32'h2, RESP_OKAY);
                src.set_irq(1'b1);
                repeat (8) @(posedge sys_clk);
                #1 chk(cpu_clk_en, 32'h0);
                src.set_irq(1'b0);
            end
            src.wake(i);
            wait_en(0, 1'b1, 2100);
            chk(n > 1980, mode[1]);
            rchk(ADDR_IRQ_STAT, {mode[1], !mode[1]}, RESP_OKAY);
            wr(ADDR_IRQ_STAT, 32'h7);
        end
    endtask

    task automatic t_hw_reset(input logic [31:0] mode);
        wr(ADDR_POWER_CONTROL_REGISTER, mode);
        wait_en(int'(mode[1]), 1'b0, 10);
        src.set_reset(1'b0);
        wait_en(2, 1'b1, RESET_CYCLES + 10);
        chk(n >= RESET_CYCLES, 32'h1);
        chk({cpu_clk_en, osc_en, state_hold}, 32'h6);
        src.set_reset(1'b1);
        wait_en(2, 1'b0, 10);
        rchk(ADDR_POWER_CONTROL_REGISTER, 32'h0, RESP_OKAY);
        // Reset out of idle also logs an idle exit
        rchk(ADDR_IRQ_STAT, 32'h4 | (mode & 32'h1), RESP_OKAY);
        wr(ADDR_IRQ_STAT, 32'h7);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Whole run is near 7200 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        reset = 1'b1;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        t_idle();
        t_wake(32'h1);
        t_wake(32'h3);
        t_hw_reset(32'h1);
        t_hw_reset(32'h2);
        results();
    end
endmodule // power_mode_ctrl_tb

bind power_mode_ctrl power_mode_ctrl_props props (
    .sys_clk(sys_clk), .reset(reset), .irq_request(irq_request),
    .hw_reset_n(hw_reset_n), .cpu_clk_en(cpu_clk_en),
    .acq_clk_en(acq_clk_en), .disp_clk_en(disp_clk_en),
    .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .state_hold(state_hold), .core_reset(core_reset));

`default_nettype wire
